/* File: design/pbsram_burst.sv */
// Burst address generator: holds the loaded address and a 2-bit burst count.
// Assumes load and step come from the core's sampled controls, one decision per edge.
`timescale 1ns/1ps
`default_nettype none
`include "pbsram_cfg.svh"

module pbsram_burst #(
    parameter bit LINEAR = 1'b1
) (
    input wire logic       clk_sys,
    input wire logic       nrst,
    pbsram_burst_if.cnt    bi
);
    import pbsram_pkg::*;

    pbsram_addr_t base_q, base_d;
    pbsram_cnt_t  cnt_q, cnt_d, cur_lo;

    // Next count: a load restarts, a step wraps inside two bits, otherwise a wait state
    always_comb begin
        cnt_d  = bi.load ? `PB_CNT_ZERO : (bi.step ? cnt_q + `PB_CNT_ONE : cnt_q);
        base_d = bi.load ? bi.base : base_q;
    end

    // Linear order adds, the other order flips the low bits
    assign cur_lo = LINEAR ? base_q[`PB_BURST_W-1:0] + cnt_q
                           : base_q[`PB_BURST_W-1:0] ^ cnt_q;
    assign bi.eff = {base_d[`PB_ADDR_W-1:`PB_BURST_W],
                     LINEAR ? base_d[`PB_BURST_W-1:0] + cnt_d
                            : base_d[`PB_BURST_W-1:0] ^ cnt_d};

    // Counter state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            base_q <= `PB_ADDR_RST;
            cnt_q  <= `PB_CNT_ZERO;
        end else begin
            base_q <= base_d;
            cnt_q  <= cnt_d;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    linear_step_a: assert property (LINEAR && bi.step && !bi.load |->
        bi.eff[`PB_BURST_W-1:0] == pbsram_cnt_t'(cur_lo + `PB_CNT_ONE))
        else $error("linear burst did not step by one");
    wait_hold_a: assert property (!bi.load && !bi.step |-> bi.eff == $past(bi.eff))
        else $error("wait state moved the burst address");
    upper_keep_a: assert property (!bi.load ##1 !bi.load |->
        bi.eff[`PB_ADDR_W-1:`PB_BURST_W] == $past(bi.eff[`PB_ADDR_W-1:`PB_BURST_W]))
        else $error("burst left its four-word block");
endmodule : pbsram_burst

`default_nettype wire

/* File: design/pbsram_burst_if.sv */
// Link between the memory core and its burst address generator.
// Assumes pbsram_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none

interface pbsram_burst_if;
    logic                    load;
    logic                    step;
    pbsram_pkg::pbsram_addr_t base;
    pbsram_pkg::pbsram_addr_t eff;
    modport ctl (output load, output step, output base, input eff);
    modport cnt (input load, input step, input base, output eff);
endinterface : pbsram_burst_if

`default_nettype wire

/* File: design/pbsram_cfg.svh */
// Sizes and idle levels for the pipelined burst memory block.
// Assumes inclusion by the package and by every design file that needs a figure.
`ifndef PBSRAM_CFG_SVH
`define PBSRAM_CFG_SVH

`define PB_ADDR_W    16
`define PB_WORDS     65536
`define PB_BYTE_W    8
`define PB_LANE_W    9
`define PB_LANES     2
`define PB_WORD_W    18
`define PB_DATA_W    16
`define PB_BURST_W   2
`define PB_CNT_ZERO  2'h0
`define PB_CNT_ONE   2'h1
`define PB_STROBE_ID 1'h1
`define PB_WE_IDLE   2'h3
`define PB_WE_LOWONL 2'h2
`define PB_WE_BOTH   2'h0
`define PB_ADDR_RST  16'h0000
`define PB_WORD_RST  18'h00000

`endif

/* File: design/pbsram_core.sv */
// Synchronous 64K x 18 burst memory with byte writes and an optional output register.
// Assumes pins are synchronous to clk_sys except oe_n; the pad ring joins the _out/_oe pairs.
`timescale 1ns/1ps
`default_nettype none
`include "pbsram_cfg.svh"

module pbsram_core #(
    parameter bit REG_OUT = 1'b1
) (
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    input  wire pbsram_pkg::pbsram_addr_t  addr,
    input  wire logic                      ce_n,
    input  wire logic                      processor_address_strobe_n,
    input  wire logic                      controller_address_strobe_n,
    input  wire logic                      burst_step_n,
    input  wire logic                      high_byte_write_n,
    input  wire logic                      low_byte_write_n,
    input  wire logic                      oe_n,
    input  wire logic [`PB_DATA_W-1:0]     data_io_bus_in,
    output var  logic [`PB_DATA_W-1:0]     data_io_bus_out,
    output var  logic                      data_io_bus_oe,
    input  wire logic                      low_parity_io_in,
    output var  logic                      low_parity_io_out,
    output var  logic                      low_parity_io_oe,
    input  wire logic                      high_parity_io_in,
    output var  logic                      high_parity_io_out,
    output var  logic                      high_parity_io_oe
);
    import pbsram_pkg::*;

    pbsram_burst_if bi ();

    pbsram_addr_t  a_q;
    pbsram_word_t  d_q, pre_q, out_q, rd_word;
    logic          ce_n_q, processor_address_strobe_n_n_q, controller_address_strobe_n_n_q, adv_n_q;
    logic [`PB_LANES-1:0] we_n_q;
    pbsram_state_t state_q, state_d;
    logic          new_c, dsel_c, wr_act, rd_act;

    // Input capture; idle levels at reset so nothing starts before the first real edge
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            a_q      <= `PB_ADDR_RST;
            d_q      <= `PB_WORD_RST;
            ce_n_q   <= `PB_STROBE_ID;
            processor_address_strobe_n_n_q <= `PB_STROBE_ID;
            controller_address_strobe_n_n_q <= `PB_STROBE_ID;
            adv_n_q  <= `PB_STROBE_ID;
            we_n_q   <= `PB_WE_IDLE;
        end else begin
            a_q      <= addr;
            d_q      <= {high_parity_io_in, data_io_bus_in[`PB_DATA_W-1:`PB_BYTE_W],
                         low_parity_io_in, data_io_bus_in[`PB_BYTE_W-1:0]};
            ce_n_q   <= ce_n;
            processor_address_strobe_n_n_q <= processor_address_strobe_n;
            controller_address_strobe_n_n_q <= controller_address_strobe_n;
            adv_n_q  <= burst_step_n;
            we_n_q   <= {high_byte_write_n, low_byte_write_n};
        end
    end

    // Cycle decode; chip select only matters when a strobe is low, as the bus promises
    always_comb begin
        new_c   = !ce_n_q && (!processor_address_strobe_n_n_q || !controller_address_strobe_n_n_q);
        dsel_c  = ce_n_q && !controller_address_strobe_n_n_q;
        state_d = new_c ? PB_SELECTED : (dsel_c ? PB_POWER_DOWN : state_q);
        wr_act  = (state_d == PB_SELECTED) && processor_address_strobe_n_n_q && !(&we_n_q);
        rd_act  = (state_d == PB_SELECTED) && !wr_act;
    end

    // Burst generator steering; advance is ignored on the edge that loads
    assign bi.load = new_c;
    assign bi.step = !new_c && !dsel_c && !adv_n_q;
    assign bi.base = a_q;

    pbsram_burst #(
        .LINEAR (REG_OUT)
    ) u_burst (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .bi      (bi)
    );

    // Selection state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= PB_POWER_DOWN;
        end else begin
            state_q <= state_d;
        end
    end

    // One array per byte lane so each lane has its own write enable
    genvar g;
    generate
        for (g = 0; g < `PB_LANES; g++) begin : g_lane
            logic [`PB_LANE_W-1:0] mem [`PB_WORDS];
            always_ff @(posedge clk_sys) begin
                if (wr_act && !we_n_q[g]) begin
                    mem[bi.eff] <= d_q[g*`PB_LANE_W +: `PB_LANE_W];
                end
            end
            assign rd_word[g*`PB_LANE_W +: `PB_LANE_W] = mem[bi.eff];
        end
    endgenerate

    // Output register; the registered variant adds a stage and merges writes into it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre_q <= `PB_WORD_RST;
            out_q <= `PB_WORD_RST;
        end else if (REG_OUT) begin
            out_q <= pre_q;
            if (rd_act) begin
                pre_q <= rd_word;
            end else if (wr_act) begin
                for (int i = 0; i < `PB_LANES; i++) begin
                    if (!we_n_q[i]) begin
                        pre_q[i*`PB_LANE_W +: `PB_LANE_W] <= d_q[i*`PB_LANE_W +: `PB_LANE_W];
                    end
                end
            end
        end else if (rd_act) begin
            out_q <= rd_word;
        end
    end

    assign data_io_bus_out    = {out_q[`PB_WORD_W-2:`PB_LANE_W], out_q[`PB_BYTE_W-1:0]};
    assign low_parity_io_out  = out_q[`PB_BYTE_W];
    assign high_parity_io_out = out_q[`PB_WORD_W-1];

    // Driver enable is combinational in oe_n so it needs no clock edge to turn off
    assign data_io_bus_oe    = !oe_n && (state_q == PB_SELECTED) && (&we_n_q);
    assign low_parity_io_oe  = data_io_bus_oe;
    assign high_parity_io_oe = data_io_bus_oe;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    read_kind_a: assert property ((&we_n_q || !processor_address_strobe_n_n_q) |-> !wr_act)
        else $error("read cycle treated as write");
    write_kind_a: assert property (wr_act |-> processor_address_strobe_n_n_q && !(&we_n_q)
        && state_d == PB_SELECTED) else $error("write without its conditions");
    oe_ignore_a: assert property (!(&we_n_q) |-> !data_io_bus_oe)
        else $error("drivers on while a byte write is sampled low");
    addr_load_a: assert property (new_c |-> bi.eff == a_q)
        else $error("new address not used by the starting cycle");
    capture_a: assert property (##1 a_q == $past(addr)
        && we_n_q == $past({high_byte_write_n, low_byte_write_n}))
        else $error("inputs not captured on the edge");
    oe_async_a: assert property (oe_n |-> !data_io_bus_oe)
        else $error("drivers on with output enable high");
    power_down_a: assert property (dsel_c && !new_c |=> state_q == PB_POWER_DOWN
        && !data_io_bus_oe) else $error("deselect did not power down");
    processor_address_strobe_n_read_a: assert property (new_c && !processor_address_strobe_n_n_q |-> rd_act)
        else $error("processor strobe did not start a read");
    lane_write_a: assert property (wr_act && we_n_q == `PB_WE_LOWONL ##1
        (!new_c && !bi.step && !dsel_c) |-> rd_word[`PB_LANE_W-1:0] ==
        $past(d_q[`PB_LANE_W-1:0])) else $error("low lane not stored");
    pass_thru_a: assert property (REG_OUT && wr_act && we_n_q == `PB_WE_BOTH
        ##1 rd_act |=> out_q == $past(d_q, 2)) else $error("write not passed through");
    flow_read_a: assert property (!REG_OUT && rd_act |=> out_q == $past(rd_word))
        else $error("read data not loaded into output register");

    write_seen_c: cover property (wr_act);
    burst_four_c: cover property (rd_act && new_c ##1 (rd_act && bi.step)[*3]);
    deselect_c: cover property (dsel_c ##1 state_q == PB_POWER_DOWN);
    pass_seen_c: cover property (wr_act ##1 rd_act && data_io_bus_oe);
endmodule : pbsram_core

`default_nettype wire

/* File: design/pbsram_pkg.sv */
// Types shared by the burst memory core, its counter and their interface.
// Assumes the configuration header sits beside this file.
`include "pbsram_cfg.svh"

package pbsram_pkg;
    typedef logic [`PB_ADDR_W-1:0]  pbsram_addr_t;
    typedef logic [`PB_WORD_W-1:0]  pbsram_word_t;
    typedef logic [`PB_BURST_W-1:0] pbsram_cnt_t;
    typedef enum logic {PB_POWER_DOWN, PB_SELECTED} pbsram_state_t;
endpackage : pbsram_pkg

/* File: test/pbsram_core_tb.sv */
// Self-checking bench for the burst memory core, registered and flow-through variants side by side.
// Assumes pbsram_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin samples_checked++; if ((sn) !== (ex)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, ex, sn); end end

module pbsram_core_tb;
    import pbsram_pkg::*;
    logic         clk_sys = 1'b0;
    logic         nrst = 1'b0;
    pbsram_addr_t addr = 16'h0000;
    logic         ce_n = 1'b1;
    logic         processor_address_strobe_n = 1'b1;
    logic         controller_address_strobe_n = 1'b1;
    logic         burst_step_n = 1'b1;
    logic         high_byte_write_n = 1'b1;
    logic         low_byte_write_n = 1'b1;
    logic         oe_n = 1'b1;
    logic         oe_want_n = 1'b0;
    logic         drv = 1'b0;
    pbsram_word_t wdata = 18'h00000;
    pbsram_word_t bus_w;
    pbsram_word_t ex;
    logic [15:0]  data_io_bus_out;
    logic         data_io_bus_oe;
    logic         low_parity_io_out;
    logic         low_parity_io_oe;
    logic         high_parity_io_out;
    logic         high_parity_io_oe;
    pbsram_word_t bus_f;
    logic [15:0]  flow_data;
    logic         flow_oe;
    logic         flow_lp;
    logic         flow_hp;
    pbsram_word_t bw [4] = '{18'h11111, 18'h22222, 18'h33333, 18'h00F0F};
    int           fails = 0;
    int           samples_checked = 0;
    int           cycles = 0;

    always #5 clk_sys = ~clk_sys;

    pbsram_core #(.REG_OUT(1'b1)) pbsram_core_inst (
        .clk_sys, .nrst, .addr, .ce_n, .processor_address_strobe_n,
        .controller_address_strobe_n, .burst_step_n, .high_byte_write_n,
        .low_byte_write_n, .oe_n, .data_io_bus_in(bus_w[15:0]), .data_io_bus_out,
        .data_io_bus_oe, .low_parity_io_in(bus_w[16]), .low_parity_io_out,
        .low_parity_io_oe, .high_parity_io_in(bus_w[17]), .high_parity_io_out,
        .high_parity_io_oe);

    pbsram_ctl_model pbsram_ctl_model_inst (.drv, .wdata, .dev_oe(data_io_bus_oe),
        .dev_w({high_parity_io_out, low_parity_io_out, data_io_bus_out}), .bus_w);

    // Flow-through twin on the same pins, with its own wire so its drive is judged alone
    pbsram_core #(.REG_OUT(1'b0)) flow_pbsram_core_inst (
        .clk_sys, .nrst, .addr, .ce_n, .processor_address_strobe_n,
        .controller_address_strobe_n, .burst_step_n, .high_byte_write_n,
        .low_byte_write_n, .oe_n, .data_io_bus_in(bus_f[15:0]), .data_io_bus_out(flow_data),
        .data_io_bus_oe(flow_oe), .low_parity_io_in(bus_f[16]), .low_parity_io_out(flow_lp),
        .low_parity_io_oe(), .high_parity_io_in(bus_f[17]), .high_parity_io_out(flow_hp),
        .high_parity_io_oe());

    pbsram_ctl_model flow_pbsram_ctl_model_inst (.drv, .wdata, .dev_oe(flow_oe),
        .dev_w({flow_hp, flow_lp, flow_data}), .bus_w(bus_f));

    // One bus cycle; ctl packs {processor strobe, controller strobe, ce_n, step}
    task automatic pins(input logic [3:0] ctl, input logic [1:0] we,
                        input pbsram_addr_t a, input pbsram_word_t d);
        @(posedge clk_sys);
        {processor_address_strobe_n, controller_address_strobe_n, ce_n, burst_step_n} <= ctl;
        {high_byte_write_n, low_byte_write_n} <= we;
        addr <= a;
        wdata <= d;
        drv <= (we != 2'h3);
        oe_n <= oe_want_n;
    endtask : pins

    // Suspend cycles with a junk address, which must not be loaded
    task automatic idle(input int n);
        repeat (n) pins(4'hF, 2'h3, 16'hFFFF, 18'h00000);
    endtask : idle

    // Output drive stays off around write data so the wire never contends
    task automatic wr(input pbsram_addr_t a, input logic [1:0] we, input pbsram_word_t d);
        oe_want_n = 1'b1;
        pins(4'h9, we, a, d);
        idle(1);
        oe_want_n = 1'b0;
    endtask : wr

    // Registered read: word on the wire two edges after the sampling edge
    // Flow-through has the word one edge earlier and holds it through the idle reads
    task automatic rd(input pbsram_addr_t a, input pbsram_word_t e, input pbsram_word_t ef);
        pins(4'h5, 2'h3, a, 18'h00000);
        idle(2);
        @(posedge clk_sys);
        #1;
        `CHK("read word", e, bus_w)
        `CHK("flow read word", ef, bus_f)
    endtask : rd

    task automatic s_lanes;
        wr(16'h1234, 2'h0, 18'h2A55A);
        rd(16'h1234, 18'h2A55A, 18'h2A55A);
        ex = (18'h2A55A & 18'h2FF00) | (18'h155A5 & 18'h100FF);
        wr(16'h1234, 2'h2, 18'h155A5);
        rd(16'h1234, ex, ex);
        ex = (ex & 18'h100FF) | (18'h3C3C3 & 18'h2FF00);
        wr(16'h1234, 2'h1, 18'h3C3C3);
        rd(16'h1234, ex, ex);
        // Processor strobe with writes low must read and leave the word alone
        oe_want_n = 1'b1;
        pins(4'h5, 2'h0, 16'h1234, 18'h3FFFF);
        oe_want_n = 1'b0;
        idle(2);
        @(posedge clk_sys);
        #1;
        `CHK("forced read", ex, bus_w)
        `CHK("flow forced read", ex, bus_f)
        rd(16'h1234, ex, ex);
    endtask : s_lanes

    task automatic s_burst;
        oe_want_n = 1'b1;
        pins(4'h9, 2'h0, 16'h0103, bw[0]);
        for (int k = 1; k < 4; k++) pins(4'hE, 2'h0, 16'hFFFF, bw[k]);
        idle(1);
        oe_want_n = 1'b0;
        // Base three: linear places words at 3,0,1,2 and the flipped order at 3,2,1,0
        for (int k = 0; k < 4; k++) rd(16'h0100 | 16'((k + 3) % 4), bw[k], bw[(4 - k) % 4]);
        pins(4'h5, 2'h3, 16'h0103, 18'h00000);
        pins(4'hE, 2'h3, 16'hFFFF, 18'h00000);
        pins(4'hE, 2'h3, 16'hFFFF, 18'h00000);
        pins(4'hF, 2'h3, 16'hFFFF, 18'h00000);
        for (int k = 0; k < 4; k++) begin
            #1;
            `CHK("burst word", bw[k < 3 ? k : 2], bus_w)
            `CHK("flow burst word", bw[k == 0 ? 1 : 2], bus_f)
            @(posedge clk_sys);
        end
    endtask : s_burst

    // Write then read at once: output register carries the new word, enable gated meanwhile
    task automatic s_pass;
        oe_want_n = 1'b1;
        pins(4'h9, 2'h0, 16'h2000, 18'h2BEEF);
        oe_want_n = 1'b0;
        pins(4'h5, 2'h3, 16'h2000, 18'h00000);
        #1;
        `CHK("write drive", 1'b0, data_io_bus_oe)
        `CHK("flow write drive", 1'b0, flow_oe)
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("pass word", 18'h2BEEF, bus_w)
        `CHK("flow pass word", 18'h2BEEF, bus_f)
        @(posedge clk_sys);
        oe_n <= 1'b1;
        #1;
        `CHK("async drive", 1'b0, data_io_bus_oe)
        `CHK("flow async drive", 1'b0, flow_oe)
    endtask : s_pass

    task automatic s_power;
        rd(16'h0101, bw[2], bw[2]);
        `CHK("selected drive", 1'b1, data_io_bus_oe)
        `CHK("flow selected drive", 1'b1, flow_oe)
        pins(4'hB, 2'h3, 16'h0101, 18'h00000);
        idle(2);
        #1;
        `CHK("down drive", 1'b0, data_io_bus_oe)
        `CHK("down parity", 2'h0, {low_parity_io_oe, high_parity_io_oe})
        `CHK("flow down drive", 1'b0, flow_oe)
    endtask : s_power

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // Hang guard: the full sequence needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            results();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        s_lanes();
        s_burst();
        s_pass();
        s_power();
        results();
    end
endmodule : pbsram_core_tb

`default_nettype wire

/* File: test/pbsram_ctl_model.sv */
// Far-side bus controller model: resolves the shared 18-bit data wire.
// Assumes the bench offers write data only on write cycles, with oe_n held high.
`timescale 1ns/1ps
`default_nettype none

module pbsram_ctl_model (
    input  wire logic                     drv,
    input  wire pbsram_pkg::pbsram_word_t wdata,
    input  wire logic                     dev_oe,
    input  wire pbsram_pkg::pbsram_word_t dev_w,
    output var  pbsram_pkg::pbsram_word_t bus_w
);
    import pbsram_pkg::*;
    pbsram_word_t last_w = 18'h00000;

    // Controller wins on write cycles; a floating wire shows the inverse of its last level
    always_comb begin
        if (drv)
            bus_w = wdata;
        else if (dev_oe)
            bus_w = dev_w;
        else
            bus_w = ~last_w;               // Keeps a float from passing as a lucky match
    end

    // Remember what was last driven
    always @(bus_w) if (drv || dev_oe) last_w = bus_w;
endmodule : pbsram_ctl_model

`default_nettype wire
